//--- design/sbtc_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// sixteen-bit timer/counter with apb registers
//
// Operation
// - count is sixteen bits in two software read/write bytes
// - count runs up from 0000 to FFFF, then wraps to 0000
// - each wrap sets a sticky overflow flag, flag register bit 0
// - interrupt request only while enable register bit 0 is set
// - control bit 1 clear: timer, one step per instruction cycle
// - control bit 1 set: counter, steps on external rising edges
// - counter edges from crystal input if oscillator enabled, else pin
// - counts only while control bit 0 is set
// - compare unit special event input clears the count
// - control bits 5:4 pick prescale 1, 2, 4 or 8
// - oscillator enabled forces both oscillator pins to inputs
// - sync control bit is ignored in timer mode
// - sync mode: prescaler output synchronised, prescaler ripples
// - sync counter in sleep: count holds, prescaler keeps counting
// - async counter keeps counting in sleep, overflow may wake core
// - any count byte write clears the prescaler
// - count write beats special event; special event sets no flag
// - control cleared on power-on reset; count never reset
module sbtc_timer (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sbtc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_COUNT_CLOCK_PIN,
  input wire logic CRYSTAL_OSC_INPUT,
  input wire logic SLEEP,
  input wire logic SPECIAL_EVENT,
  input wire logic [1:0] PORT_DIRECTION_BITS,
  output logic [1:0] OSC_PIN_DIR,
  output logic CRYSTAL_OSC_DRIVE,
  output logic OVF_IRQ,
  output logic WAKE
);

  // ====================================================================
  // state
  sbtc_pkg::sbtc_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] count_low_byte_reg, count_low_byte_next;
  logic [7:0] count_high_byte_reg, count_high_byte_next;
  logic overflow_flag_reg, overflow_flag_next;
  logic overflow_irq_enable_reg, overflow_irq_enable_next;
  logic [1:0] phase_reg, phase_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic ovf_irq_reg, ovf_irq_next;
  logic wake_reg, wake_next;
  logic [1:0] osc_dir_reg, osc_dir_next;
  logic osc_drive_reg, osc_drive_next;

  // ====================================================================
  // bus decode
  logic access, rd_phase, wr_en, mapped;
  logic wr_low, wr_high, wr_flag, wr_enable, wr_ctrl, cnt_wr;
  logic [15:0] sixteen_bit_count;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == sbtc_pkg::OFS_COUNT_LOW) ||
                (a == sbtc_pkg::OFS_COUNT_HIGH) ||
                (a == sbtc_pkg::OFS_FLAG) ||
                (a == sbtc_pkg::OFS_ENABLE) ||
                (a == sbtc_pkg::OFS_CTRL);
  endfunction : is_mapped

  assign access = PSEL && PENABLE;
  assign rd_phase = access && !pready_reg;
  assign wr_en = access && pready_reg && PWRITE;
  assign mapped = is_mapped(PADDR);
  assign wr_low = wr_en && (PADDR == sbtc_pkg::OFS_COUNT_LOW);
  assign wr_high = wr_en && (PADDR == sbtc_pkg::OFS_COUNT_HIGH);
  assign wr_flag = wr_en && (PADDR == sbtc_pkg::OFS_FLAG);
  assign wr_enable = wr_en && (PADDR == sbtc_pkg::OFS_ENABLE);
  assign wr_ctrl = wr_en && (PADDR == sbtc_pkg::OFS_CTRL);
  assign cnt_wr = wr_low || wr_high;
  assign sixteen_bit_count = {count_high_byte_reg, count_low_byte_reg};

  // ====================================================================
  // clock sources
  logic [1:0] pin_rise;
  logic instr_tick, sel_edge, pre_edge, pre_out, inc, wrap;

  sbtc_sync #(
    .W(2)
  ) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din({CRYSTAL_OSC_INPUT, EXT_COUNT_CLOCK_PIN}),
    .rise(pin_rise)
  );

  always_comb
  begin
    phase_next = phase_reg + 2'h1;
    instr_tick = (32'(phase_reg) == sbtc_pkg::INSTR_CYCLES - 1);
    if (ctrl_reg.clock_source_select)
    begin
      // counter mode, source chosen by oscillator enable
      sel_edge = ctrl_reg.crystal_osc_enable ? pin_rise[1]
                                             : pin_rise[0];
    end
    else
    begin
      // timer mode; core clock stops in sleep
      sel_edge = instr_tick && !SLEEP;
    end
    pre_edge = sel_edge && ctrl_reg.run_enable;
  end

  sbtc_prescaler #(
    .W(3)
  ) u_prescaler (
    .clk(CORE_CLK),
    .rst(RESET),
    .clr(cnt_wr),
    .edge_in(pre_edge),
    .sel(ctrl_reg.prescale),
    .edge_out(pre_out)
  );

  always_comb
  begin
    // sync control only matters in counter mode
    if (ctrl_reg.clock_source_select && !ctrl_reg.sync_disable_n)
    begin
      inc = pre_out && !SLEEP;
    end
    else
    begin
      inc = pre_out;
    end
    wrap = inc && (sixteen_bit_count == sbtc_pkg::COUNT_MAX);
  end

  // ====================================================================
  // count and flag
  always_comb
  begin
    count_low_byte_next = count_low_byte_reg;
    count_high_byte_next = count_high_byte_reg;
    if (cnt_wr)
    begin
      // write wins over special event and increment
      if (wr_low)
      begin
        count_low_byte_next = PWDATA[7:0];
      end
      if (wr_high)
      begin
        count_high_byte_next = PWDATA[7:0];
      end
    end
    else if (SPECIAL_EVENT)
    begin
      {count_high_byte_next, count_low_byte_next} =
        sbtc_pkg::COUNT_MIN;
    end
    else if (inc)
    begin
      {count_high_byte_next, count_low_byte_next} =
        sixteen_bit_count + 16'h0001;
    end
    overflow_flag_next = overflow_flag_reg;
    if (wr_flag)
    begin
      overflow_flag_next = PWDATA[sbtc_pkg::FLAG_OVF_BIT];
    end
    if (wrap && !cnt_wr && !SPECIAL_EVENT)
    begin
      overflow_flag_next = 1'b1;
    end
    overflow_irq_enable_next = overflow_irq_enable_reg;
    if (wr_enable)
    begin
      overflow_irq_enable_next = PWDATA[sbtc_pkg::ENABLE_OVF_BIT];
    end
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      ctrl_next = PWDATA[sbtc_pkg::CTRL_W-1:0];
    end
  end

  // ====================================================================
  // outputs and bus answer
  always_comb
  begin
    ovf_irq_next = overflow_flag_reg && overflow_irq_enable_reg;
    wake_next = ovf_irq_next && SLEEP;
    osc_dir_next = ctrl_reg.crystal_osc_enable ? sbtc_pkg::OSC_PINS_INPUT
                                               : PORT_DIRECTION_BITS;
    osc_drive_next = ctrl_reg.crystal_osc_enable;
    pready_next = rd_phase;
    pslverr_next = rd_phase && !mapped;
    prdata_next = prdata_reg;
    if (rd_phase)
    begin
      case (PADDR)
        sbtc_pkg::OFS_COUNT_LOW: prdata_next = {24'h000000, count_low_byte_reg};
        sbtc_pkg::OFS_COUNT_HIGH:
          prdata_next = {24'h000000, count_high_byte_reg};
        sbtc_pkg::OFS_FLAG: prdata_next = {31'h00000000, overflow_flag_reg};
        sbtc_pkg::OFS_ENABLE:
          prdata_next = {31'h00000000, overflow_irq_enable_reg};
        sbtc_pkg::OFS_CTRL: prdata_next = {26'h0000000, ctrl_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    // count bytes have no reset; a special event still clears them during reset
    count_low_byte_reg <= count_low_byte_next;
    count_high_byte_reg <= count_high_byte_next;
    if (RESET)
    begin
      ctrl_reg <= sbtc_pkg::CTRL_RESET;
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
      phase_reg <= 2'h0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      osc_dir_reg <= 2'h0;
      osc_drive_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      overflow_flag_reg <= overflow_flag_next;
      overflow_irq_enable_reg <= overflow_irq_enable_next;
      phase_reg <= phase_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ovf_irq_reg <= ovf_irq_next;
      wake_reg <= wake_next;
      osc_dir_reg <= osc_dir_next;
      osc_drive_reg <= osc_drive_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign OVF_IRQ = ovf_irq_reg;
  assign WAKE = wake_reg;
  assign OSC_PIN_DIR = osc_dir_reg;
  assign CRYSTAL_OSC_DRIVE = osc_drive_reg;

  // ====================================================================
  // checks
  property p_wrap_sets_flag;
    @(posedge CORE_CLK) disable iff (RESET)
      (wrap && !cnt_wr && !SPECIAL_EVENT) |=> overflow_flag_reg;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag)
    else $error("wrap did not set overflow flag");

  property p_irq_gated;
    @(posedge CORE_CLK) disable iff (RESET)
      !$past(RESET) |->
        (OVF_IRQ == $past(overflow_flag_reg && overflow_irq_enable_reg));
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt request not flag and enable");

  property p_stopped_holds;
    @(posedge CORE_CLK) disable iff (RESET)
      (!ctrl_reg.run_enable && !cnt_wr && !SPECIAL_EVENT) |=>
        (sixteen_bit_count == $past(sixteen_bit_count));
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("count moved while stopped");

  property p_special_clears;
    @(posedge CORE_CLK) disable iff (RESET)
      (SPECIAL_EVENT && !cnt_wr) |=> (sixteen_bit_count == 16'h0000);
  endproperty
  a_special_clears: assert property (p_special_clears)
    else $error("special event did not clear count");

  property p_write_beats_special;
    @(posedge CORE_CLK) disable iff (RESET)
      (SPECIAL_EVENT && wr_low) |=>
        (count_low_byte_reg == $past(PWDATA[7:0]));
  endproperty
  a_write_beats_special: assert property (p_write_beats_special)
    else $error("special event overrode count write");

  property p_special_no_flag;
    @(posedge CORE_CLK) disable iff (RESET)
      (SPECIAL_EVENT && !overflow_flag_reg && !wr_flag) |=>
        !overflow_flag_reg;
  endproperty
  a_special_no_flag: assert property (p_special_no_flag)
    else $error("special event set overflow flag");

  property p_osc_pins_input;
    @(posedge CORE_CLK) disable iff (RESET)
      ctrl_reg.crystal_osc_enable |=> (OSC_PIN_DIR == 2'h3);
  endproperty
  a_osc_pins_input: assert property (p_osc_pins_input)
    else $error("oscillator pins not forced to input");

  property p_step_by_one;
    @(posedge CORE_CLK) disable iff (RESET)
      (inc && !cnt_wr && !SPECIAL_EVENT) |=>
        (sixteen_bit_count == 16'($past(sixteen_bit_count) + 16'h0001));
  endproperty
  a_step_by_one: assert property (p_step_by_one)
    else $error("count did not step by one");

  property p_ctrl_high_zero;
    @(posedge CORE_CLK) disable iff (RESET)
      (rd_phase && PADDR == 8'h10) |=> (PRDATA[31:6] == 26'h0000000);
  endproperty
  a_ctrl_high_zero: assert property (p_ctrl_high_zero)
    else $error("unused control bits read nonzero");

  property p_sync_sleep_holds;
    @(posedge CORE_CLK) disable iff (RESET)
      (SLEEP && ctrl_reg.clock_source_select && !ctrl_reg.sync_disable_n &&
       !cnt_wr && !SPECIAL_EVENT) |=>
        (sixteen_bit_count == $past(sixteen_bit_count));
  endproperty
  a_sync_sleep_holds: assert property (p_sync_sleep_holds)
    else $error("synchronised count moved in sleep");

endmodule : sbtc_timer
`default_nettype wire

//--- design/sbtc_pkg.sv
// ======================================================================
// constants and types of the sixteen-bit timer/counter
package sbtc_pkg;

  // ====================================================================
  // register map, byte addresses on the apb
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;

  // ====================================================================
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLK_SEL_BIT = 1;
  localparam int CTRL_SYNC_N_BIT = 2;
  localparam int CTRL_OSC_EN_BIT = 3;
  localparam int CTRL_PRESCALE_LSB = 4;
  localparam int CTRL_W = 6;
  localparam int FLAG_OVF_BIT = 0;
  localparam int ENABLE_OVF_BIT = 0;

  // ====================================================================
  // reset and limit values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [1:0] OSC_PINS_INPUT = 2'h3;

  // ====================================================================
  // timing: core clock is the oscillator, instruction cycle is fosc/4
  localparam int CORE_PERIOD_NS = 100;
  localparam int FOSC_PER_INSTR = 4;
  localparam int INSTR_PERIOD_NS = CORE_PERIOD_NS * FOSC_PER_INSTR;
  localparam int INSTR_CYCLES = INSTR_PERIOD_NS / CORE_PERIOD_NS;

  // ====================================================================
  // control register layout
  typedef struct packed {
    logic [1:0] prescale;
    logic crystal_osc_enable;
    logic sync_disable_n;
    logic clock_source_select;
    logic run_enable;
  } sbtc_ctrl_t;

endpackage : sbtc_pkg

//--- design/sbtc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// three-stage pin synchroniser with rising-edge pulse
module sbtc_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise
);

  logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [W-1:0] lvl_next;

  // level follows once stages two and three agree
  always_comb
  begin
    lvl_next = lvl_reg;
    for (int i = 0; i < W; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        lvl_next[i] = s3_reg[i];
      end
    end
    rise = lvl_next & ~lvl_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

endmodule : sbtc_sync
`default_nettype wire

//--- design/sbtc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================================
// ripple-style prescaler: 1:1, 1:2, 1:4, 1:8
module sbtc_prescaler #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic edge_in,
  input wire logic [1:0] sel,
  output logic edge_out
);

  logic [W-1:0] cnt_reg, cnt_next;
  logic [W-1:0] lim;

  // low bits that must all be one before the output fires
  function automatic logic [W-1:0] ratio_mask(input logic [1:0] s);
    ratio_mask = W'((4'h1 << s) - 4'h1);
  endfunction : ratio_mask

  always_comb
  begin
    lim = ratio_mask(sel);
    cnt_next = cnt_reg;
    edge_out = 1'b0;
    if (clr)
    begin
      cnt_next = '0;
    end
    else if (edge_in)
    begin
      cnt_next = cnt_reg + W'(1);
      edge_out = ((cnt_reg & lim) == lim);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  property p_clear_empties;
    @(posedge clk) disable iff (rst)
      clr |=> (cnt_reg == '0);
  endproperty
  a_clear_empties: assert property (p_clear_empties)
    else $error("prescaler not cleared");

  property p_one_to_one;
    @(posedge clk) disable iff (rst)
      (!clr && edge_in && sel == 2'h0) |-> edge_out;
  endproperty
  a_one_to_one: assert property (p_one_to_one)
    else $error("1:1 prescale dropped an edge");

endmodule : sbtc_prescaler
`default_nettype wire

//--- dv/sbtc_clk_src.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// external count clock and crystal source
module sbtc_clk_src #(
  parameter int HALF_NS = 300
) (
  output var logic pin,
  output var logic xtal
);
  // both lines rest low between bursts
  initial
  begin
    {xtal, pin} <= 2'h0;
  end
  // ======================================
  // n rising edges on the pin (sel 0) or the crystal (sel 1)
  task automatic edges(input bit sel, input int n);
    repeat (n)
    begin
      {xtal, pin} <= sel ? 2'h2 : 2'h1;
      #HALF_NS;
      {xtal, pin} <= 2'h0;
      #HALF_NS;
    end
  endtask : edges
endmodule : sbtc_clk_src
`default_nettype wire

//--- dv/sixteen_bit_timer_counter_test.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// self-checking bench of the timer/counter
module sixteen_bit_timer_counter_test;
  logic clk, rst, psel, pen, pwr, sleep, sev;
  logic pready, pslverr, pin, xtal, drv, irq, wake, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] dir_in, dir_out;
  logic [15:0] cnt, hold;
  int fail_count, num_checks, exp, n, p;

  sbtc_timer dut_u (
    .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_COUNT_CLOCK_PIN(pin),
    .CRYSTAL_OSC_INPUT(xtal), .SLEEP(sleep), .SPECIAL_EVENT(sev),
    .PORT_DIRECTION_BITS(dir_in), .OSC_PIN_DIR(dir_out),
    .CRYSTAL_OSC_DRIVE(drv), .OVF_IRQ(irq), .WAKE(wake)
  );
  sbtc_clk_src src_u (.pin(pin), .xtal(xtal));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ======================================
  // compare, bus cycles, closing
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'h0, a, 32'h0);
    check(rd, want);
  endtask : rdchk
  task automatic setc(input logic [15:0] v);
    wr(sbtc_pkg::OFS_COUNT_LOW, {24'h0, v[7:0]});
    wr(sbtc_pkg::OFS_COUNT_HIGH, {24'h0, v[15:8]});
  endtask : setc
  task automatic getc;
    apb(1'h0, sbtc_pkg::OFS_COUNT_LOW, 32'h0);
    cnt[7:0] = rd[7:0];
    apb(1'h0, sbtc_pkg::OFS_COUNT_HIGH, 32'h0);
    cnt[15:8] = rd[7:0];
  endtask : getc
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #2000000;
    fail_count++;
    end_of_test();
  end
  // ======================================
  // main sequence
  initial
  begin
    // special event clears the unreset count while reset is held
    {rst, psel, pen, pwr, sleep, sev} = 6'h21;
    paddr = 8'h0;
    pwdata = 32'h0;
    dir_in = 2'h0;
    fail_count = 0;
    num_checks = 0;
    n = $urandom(32'h4415);
    cyc(5);
    rst <= 1'h0;
    sev <= 1'h0;
    rdchk(sbtc_pkg::OFS_CTRL, 32'h0);
    rdchk(sbtc_pkg::OFS_FLAG, 32'h0);
    wr(8'h14, 32'hFF);
    check(err, 1'h1);
    rdchk(8'h14, 32'h0);
    check(err, 1'h1);
    wr(sbtc_pkg::OFS_CTRL, 32'hC0);
    rdchk(sbtc_pkg::OFS_CTRL, 32'h0);
    setc(16'h1234);
    wr(sbtc_pkg::OFS_COUNT_LOW, 32'h56);
    getc();
    check(cnt, 16'h1256);
    // timer mode, sync bit set and ignored
    for (p = 0; p < 4; p++)
    begin
      wr(sbtc_pkg::OFS_CTRL, 32'h0);
      setc(16'h0);
      wr(sbtc_pkg::OFS_CTRL, 32'h5 | p << 4);
      cyc(64);
      wr(sbtc_pkg::OFS_CTRL, 32'h0);
      getc();
      exp = 68 / (4 << p);
      check(cnt + 1 >= exp && cnt <= exp + 1, 1'h1);
    end
    hold = cnt;
    cyc(40);
    getc();
    check(cnt, hold);
    // synchronised counter, pin or crystal, each prescale
    for (p = 0; p < 4; p++)
    begin
      dir_in <= 2'($urandom);
      wr(sbtc_pkg::OFS_CTRL, 32'h3 | p << 4 | p[0] << 3);
      setc(16'h100 * p);
      n = $urandom_range(24, 1);
      src_u.edges(p[0], n);
      src_u.edges(!p[0], 3);
      cyc(10);
      getc();
      check(cnt, 16'h100 * p + (n >> p));
      check(dir_out, p[0] ? sbtc_pkg::OSC_PINS_INPUT : dir_in);
      check(drv, p[0]);
    end
    // count write clears the prescaler
    wr(sbtc_pkg::OFS_CTRL, 32'h33);
    setc(16'h0);
    src_u.edges(0, 5);
    cyc(10);
    wr(sbtc_pkg::OFS_COUNT_LOW, 32'h0);
    src_u.edges(0, 4);
    cyc(10);
    getc();
    check(cnt, 16'h0);
    src_u.edges(0, 4);
    cyc(10);
    getc();
    check(cnt, 16'h1);
    // wrap, sticky flag, masked request
    wr(sbtc_pkg::OFS_CTRL, 32'h0);
    setc(16'hFFF8);
    wr(sbtc_pkg::OFS_CTRL, 32'h1);
    cyc(60);
    wr(sbtc_pkg::OFS_CTRL, 32'h0);
    getc();
    check(cnt < 16'h10, 1'h1);
    cyc(20);
    rdchk(sbtc_pkg::OFS_FLAG, 32'h1);
    check(irq, 1'h0);
    wr(sbtc_pkg::OFS_ENABLE, 32'h1);
    cyc(2);
    check(irq, 1'h1);
    wr(sbtc_pkg::OFS_FLAG, 32'h0);
    cyc(2);
    check(irq, 1'h0);
    // special event clears, loses to a write, sets no flag
    setc(16'h1234);
    sev <= 1'h1;
    cyc(2);
    sev <= 1'h0;
    cyc(1);
    getc();
    check(cnt, 16'h0);
    rdchk(sbtc_pkg::OFS_FLAG, 32'h0);
    sev <= 1'h1;
    wr(sbtc_pkg::OFS_COUNT_LOW, 32'h5A);
    sev <= 1'h0;
    getc();
    check(cnt, 16'h5A);
    // asynchronous counter runs in sleep and wakes
    wr(sbtc_pkg::OFS_CTRL, 32'h7);
    setc(16'hFFFE);
    sleep <= 1'h1;
    src_u.edges(0, 3);
    cyc(10);
    check(wake, 1'h1);
    sleep <= 1'h0;
    getc();
    check(cnt, 16'h1);
    rdchk(sbtc_pkg::OFS_FLAG, 32'h1);
    // synchronised counter holds in sleep, prescaler runs on
    wr(sbtc_pkg::OFS_FLAG, 32'h0);
    wr(sbtc_pkg::OFS_CTRL, 32'h13);
    setc(16'h0);
    sleep <= 1'h1;
    src_u.edges(0, 3);
    cyc(10);
    sleep <= 1'h0;
    getc();
    check(cnt, 16'h0);
    src_u.edges(0, 1);
    cyc(10);
    getc();
    check(cnt, 16'h1);
    // second reset keeps the count
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    rdchk(sbtc_pkg::OFS_CTRL, 32'h0);
    getc();
    check(cnt, 16'h1);
    end_of_test();
  end
endmodule : sixteen_bit_timer_counter_test
`default_nettype wire
